// ### osc_ctrl.v
// Oscillator selection, switching, divider and trim registers on a Wishbone slave.
// Assumes the oscillators, PLL and fail-safe monitor live outside and report status
// on clk_i; their asynchronous status inputs are synchronised here.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`include "osc_ctrl_regs.vh"
module osc_ctrl (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Configuration straps
    input  wire [2:0]  initial_source_config_i,
    input  wire        switching_config_bit_i,
    input  wire        monitor_config_bit_i,
    // Oscillator system status
    input  wire        pll_locked_i,
    input  wire        source_ready_i,
    input  wire        new_clock_tick_i,
    input  wire        failsafe_monitor_fail_i,
    input  wire        interrupt_i,
    input  wire        postscale_tick_i,
    // Controls out
    output reg  [2:0]  active_source_o,
    output reg  [2:0]  target_source_o,
    output reg         switch_busy_o,
    output reg         secondary_osc_run_o,
    output reg  [5:0]  fast_rc_trim_o,
    output wire        postscale_pulse_o,
    output wire        cpu_tick_o
);
    // ==========================================================
    // Switch state machine codes
    localparam ST_IDLE   = 2'h0;
    localparam ST_WAIT   = 2'h1;
    localparam ST_SETTLE = 2'h2;

    // ==========================================================
    // Register state
    reg  [2:0] next_source_sel;      // Target source
    reg        selection_freeze;     // Set-only lock
    reg        pll_lock;             // Lock status
    reg        clock_failure_flag;   // Sticky failure
    reg        secondary_osc_enable; // Secondary run enable
    reg        switch_request;       // Switch in progress
    reg        wake_restores_ratio;  // Interrupt ends reduction
    reg  [2:0] slow_cpu_ratio;       // Reduction exponent
    reg        ratio_reduce_enable;  // Reduction on
    reg  [2:0] fast_rc_postscale;    // Fast RC divisor code
    reg  [1:0] state;                // Switch sequencer
    reg  [3:0] settle_count;         // New-clock cycles seen
    reg  [1:0] key_high;             // High byte unlock progress
    reg  [1:0] key_low;              // Low byte unlock progress
    reg        init_done;            // Straps captured
    // Synchronisers
    reg  [1:0] lock_sync;
    reg  [1:0] ready_sync;
    reg  [1:0] fail_sync;
    reg  [1:0] tick_sync;
    reg        tick_prev;

    wire       new_tick;
    wire       access;
    wire       wr;
    wire       at_sel;
    wire       at_div;
    wire       at_tune;
    wire       fsm_on;
    wire       frozen;
    wire       switch_on;
    wire       hi_wr;
    wire       lo_wr;
    wire       hi_open;
    wire       lo_open;
    wire       uses_pll;
    wire       fail_set;
    wire       fail_clr;
    wire [15:0] sel_word;
    wire [3:0] cpu_shift;
    wire [3:0] post_shift;
    wire       post_src;

    // ==========================================================
    // Postscale code to shift; the top code jumps to 256
    function [3:0] post_to_shift;
        input [2:0] code;
        begin
            post_to_shift = (code == 3'h7) ? 4'h8 : {1'b0, code};
        end
    endfunction

    // ==========================================================
    // Decode
    assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr        = access & wb_we_i;
    assign at_sel    = (wb_adr_i == `OFS_SELECT_STATUS);
    assign at_div    = (wb_adr_i == `OFS_DIVIDER_CONTROL);
    assign at_tune   = (wb_adr_i == `OFS_FAST_RC_TUNE);
    assign switch_on = ~switching_config_bit_i;
    assign fsm_on    = ~switching_config_bit_i & ~monitor_config_bit_i;
    assign frozen    = fsm_on & selection_freeze;                           // [R4] [R5]
    assign hi_wr     = wr & at_sel & wb_sel_i[1];
    assign lo_wr     = wr & at_sel & wb_sel_i[0];
    assign hi_open   = (key_high == 2'h2);
    assign lo_open   = (key_low == 2'h2);
    assign uses_pll  = (active_source_o == `SRC_FAST_RC_PLL) |
                       (active_source_o == `SRC_PRIMARY_PLL);
    assign new_tick  = tick_sync[1] & ~tick_prev;
    assign fail_set  = fsm_on & fail_sync[1];
    // Write of zero to the flag bit clears it, low byte unlocked or not
    assign fail_clr  = lo_wr & ~wb_dat_i[`SEL_FAIL_BIT];                   // [R8]

    // Read word; unimplemented bits are zero [R17]
    assign sel_word = {1'b0, active_source_o, 1'b0, next_source_sel,
                       selection_freeze, 1'b0, pll_lock, 1'b0,
                       clock_failure_flag, 1'b0, secondary_osc_enable, switch_request};

    // ==========================================================
    // Synchronisers for outside status; only the second stage is read
    always @(posedge clk_i) begin
        if (rst_i) begin
            lock_sync  <= 2'h0;
            ready_sync <= 2'h0;
            fail_sync  <= 2'h0;
            tick_sync  <= 2'h0;
            tick_prev  <= 1'b0;
        end else begin
            lock_sync  <= {lock_sync[0], pll_locked_i};
            ready_sync <= {ready_sync[0], source_ready_i};
            fail_sync  <= {fail_sync[0], failsafe_monitor_fail_i};
            tick_sync  <= {tick_sync[0], new_clock_tick_i};
            tick_prev  <= tick_sync[1];
        end
    end

    // ==========================================================
    // Unlock key trackers; any other byte write resets progress
    always @(posedge clk_i) begin
        if (rst_i) begin
            key_high <= 2'h0;
            key_low  <= 2'h0;
        end else begin
            if (hi_wr) begin
                if (key_high == 2'h0 && wb_dat_i[15:8] == `KEY_HIGH_FIRST)
                    key_high <= 2'h1;
                else if (key_high == 2'h1 && wb_dat_i[15:8] == `KEY_HIGH_SECOND)
                    key_high <= 2'h2;                                      // [R18]
                else
                    key_high <= 2'h0;
            end
            if (lo_wr) begin
                if (key_low == 2'h0 && wb_dat_i[7:0] == `KEY_LOW_FIRST)
                    key_low <= 2'h1;
                else if (key_low == 2'h1 && wb_dat_i[7:0] == `KEY_LOW_SECOND)
                    key_low <= 2'h2;                                       // [R18]
                else
                    key_low <= 2'h0;
            end
        end
    end

    // ==========================================================
    // Select/status register and switch sequencer
    always @(posedge clk_i) begin
        if (rst_i) begin
            init_done            <= 1'b0;
            active_source_o      <= `SRC_FAST_RC;
            next_source_sel      <= `SRC_FAST_RC;
            selection_freeze     <= 1'b0;
            pll_lock             <= 1'b0;
            clock_failure_flag   <= 1'b0;
            secondary_osc_enable <= 1'b0;
            switch_request       <= 1'b0;
            state                <= ST_IDLE;
            settle_count         <= 4'h0;
        end else if (!init_done) begin
            // Straps are caught on the first edge after release
            init_done       <= 1'b1;
            active_source_o <= initial_source_config_i;                   // [R1] [R3]
            next_source_sel <= initial_source_config_i;                   // [R2] [R3]
        end else begin
            // Lock follows the PLL only while a PLL mode runs
            pll_lock <= uses_pll & lock_sync[1];                           // [R6] [R7]
            // Set wins over a clearing write in the same cycle
            if (fail_set)
                clock_failure_flag <= 1'b1;                                // [R8]
            else if (fail_clr)
                clock_failure_flag <= 1'b0;                                // [R21]
            // High byte: next source, only when unlocked and not frozen
            if (hi_wr && hi_open && !frozen && state == ST_IDLE &&
                wb_dat_i[15:8] != `KEY_HIGH_FIRST)
                next_source_sel <= wb_dat_i[`SEL_NEXT_MSB:`SEL_NEXT_LSB];  // [R2] [R4]
            // Low byte: freeze set-only and secondary enable need no key
            if (lo_wr) begin
                if (wb_dat_i[`SEL_FREEZE_BIT])
                    selection_freeze <= 1'b1;                              // [R4]
                secondary_osc_enable <= wb_dat_i[`SEL_SEC_EN_BIT];         // [R9]
            end
            case (state)
                ST_IDLE: begin
                    if (lo_wr && lo_open && switch_on && !frozen &&
                        wb_dat_i[`SEL_SWITCH_BIT]) begin                   // [R10] [R20]
                        if (next_source_sel != active_source_o) begin
                            switch_request     <= 1'b1;
                            pll_lock           <= 1'b0;                    // [R7]
                            if (!fail_set)
                                clock_failure_flag <= 1'b0;
                            state              <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    pll_lock     <= 1'b0;                                  // [R7]
                    settle_count <= 4'h0;
                    // New source running, and locked if it uses the PLL
                    if (ready_sync[1] &&
                        (!(next_source_sel == `SRC_FAST_RC_PLL ||
                           next_source_sel == `SRC_PRIMARY_PLL) || lock_sync[1]))
                        state <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (new_tick) begin
                        if (settle_count == `SETTLE_NEW_CYCLES - 1) begin
                            active_source_o <= next_source_sel;            // [R19]
                            switch_request  <= 1'b0;                       // [R10]
                            state           <= ST_IDLE;
                        end else begin
                            settle_count <= settle_count + 4'h1;           // [R19]
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Divider control and trim registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_restores_ratio <= 1'b0;
            slow_cpu_ratio      <= `DIV_RATIO_RESET;                       // [R12]
            ratio_reduce_enable <= 1'b0;
            fast_rc_postscale   <= `DIV_POST_RESET;                        // [R14]
            fast_rc_trim_o      <= `TRIM_RESET;                            // [R16]
        end else begin
            if (wr && at_div && wb_sel_i[1]) begin
                wake_restores_ratio <= wb_dat_i[`DIV_WAKE_BIT];
                slow_cpu_ratio      <= wb_dat_i[`DIV_RATIO_MSB:`DIV_RATIO_LSB];
                ratio_reduce_enable <= wb_dat_i[`DIV_REDUCE_BIT];
                fast_rc_postscale   <= wb_dat_i[`DIV_POST_MSB:`DIV_POST_LSB];
            end
            // Interrupt clear beats a concurrent write
            if (interrupt_i && wake_restores_ratio)
                ratio_reduce_enable <= 1'b0;                               // [R11]
            if (wr && at_tune && wb_sel_i[0])
                fast_rc_trim_o <= wb_dat_i[5:0];                           // [R16] [R17]
        end
    end

    // ==========================================================
    // Outputs mirrored from registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            target_source_o     <= `SRC_FAST_RC;
            switch_busy_o       <= 1'b0;
            secondary_osc_run_o <= 1'b0;
        end else begin
            target_source_o     <= next_source_sel;
            switch_busy_o       <= switch_request;
            secondary_osc_run_o <= secondary_osc_enable;                   // [R9]
        end
    end

    // ==========================================================
    // Bus answer: one-cycle ack, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (access) begin
                if (at_sel)
                    wb_dat_o <= {16'h0000, sel_word};
                else if (at_div)
                    wb_dat_o <= {16'h0000, wake_restores_ratio, slow_cpu_ratio,
                                 ratio_reduce_enable, fast_rc_postscale, 8'h00};
                else if (at_tune)
                    wb_dat_o <= {26'h000_0000, fast_rc_trim_o};            // [R17]
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Clock enables: postscaler on either divided RC source, CPU reduction
    assign post_src   = (active_source_o == `SRC_FAST_RC_DIV) |
                        (active_source_o == `SRC_LP_FAST_RC_DIV);          // [R14] [R15]
    assign post_shift = post_src ? post_to_shift(fast_rc_postscale) : 4'h0;
    assign cpu_shift  = ratio_reduce_enable ? {1'b0, slow_cpu_ratio} : 4'h0; // [R12] [R13]

    rate_divider #(.WIDTH(9)) u_post (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (postscale_tick_i),
        .shift_i (post_shift),
        .pulse_o (postscale_pulse_o)
    );

    rate_divider #(.WIDTH(8)) u_cpu (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (postscale_pulse_o),
        .shift_i (cpu_shift),
        .pulse_o (cpu_tick_o)
    );
endmodule

// ### osc_ctrl_regs.vh
// Constants for the oscillator control register block: offsets, fields, resets, codes.
// Assumes a classic Wishbone slave with 32-bit data, registers in the low 16 bits.
//
// Contract
// R1: current_source_sel bits 14-12, hardware updated
// R2: next_source_sel bits 10-8, writable target
// R3: Reset loads both fields from config
// R4: selection_freeze set-only, blocks changes when fail-safe on
// R5: Fail-safe off: selection never locked
// R6: PLL lock bit 5 follows lock/timer
// R7: Lock bit zero on switch, non-PLL mode
// R8: clock_failure_flag set by monitor, write clears
// R9: secondary_osc_enable bit 1 gates oscillator
// R10: switch_request starts switch, hardware clears
// R11: wake_restores_ratio clears ratio_reduce_enable on interrupt
// R12: slow_cpu_ratio power-of-two ratio, resets 011
// R13: ratio_reduce_enable applies slow_cpu_ratio to CPU
// R14: fast_rc_postscale divides divided fast RC
// R15: Same postscale for low-power divided source
// R16: fast_rc_trim signed six bits, reset zero
// R17: Unimplemented bits ignore writes, read zero
// R18: Software unlocks bytes with key pairs first
// R19: Wait ten new-clock cycles, then commit switch
// R20: Switching disabled: switch_request held zero
// R21: clock_failure_flag sticky until software write
`ifndef OSC_CTRL_REGS_VH
`define OSC_CTRL_REGS_VH

// ==========================================================
// Register byte offsets
`define OFS_SELECT_STATUS    8'h00
`define OFS_DIVIDER_CONTROL  8'h04
`define OFS_FAST_RC_TUNE     8'h08

// ==========================================================
// Select/status fields
`define SEL_CUR_MSB          14
`define SEL_CUR_LSB          12
`define SEL_NEXT_MSB         10
`define SEL_NEXT_LSB         8
`define SEL_FREEZE_BIT       7
`define SEL_LOCK_BIT         5
`define SEL_FAIL_BIT         3
`define SEL_SEC_EN_BIT       1
`define SEL_SWITCH_BIT       0

// ==========================================================
// Divider control fields and reset
`define DIV_WAKE_BIT         15
`define DIV_RATIO_MSB        14
`define DIV_RATIO_LSB        12
`define DIV_REDUCE_BIT       11
`define DIV_POST_MSB         10
`define DIV_POST_LSB         8
`define DIV_RATIO_RESET      3'h3
`define DIV_POST_RESET       3'h1
`define TRIM_RESET           6'h00

// ==========================================================
// Unlock keys
`define KEY_HIGH_FIRST       8'h78
`define KEY_HIGH_SECOND      8'h9a
`define KEY_LOW_FIRST        8'h46
`define KEY_LOW_SECOND       8'h57

// ==========================================================
// Source codes
`define SRC_FAST_RC          3'h0
`define SRC_FAST_RC_PLL      3'h1
`define SRC_PRIMARY          3'h2
`define SRC_PRIMARY_PLL      3'h3
`define SRC_SECONDARY        3'h4
`define SRC_LOW_POWER_RC     3'h5
`define SRC_LP_FAST_RC_DIV   3'h6
`define SRC_FAST_RC_DIV      3'h7

// ==========================================================
// Timing
`define SETTLE_NEW_CYCLES    10

`endif

// ### rate_divider.v
// Programmable power-of-two enable divider: one-cycle pulse every 2**shift ticks.
// Assumes tick_i is a one-cycle enable on clk_i.
module rate_divider #(
    parameter WIDTH = 8
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             tick_i,
    input  wire [3:0]       shift_i,
    output reg              pulse_o
);
    // ==========================================================
    // Free running counter
    reg  [WIDTH-1:0] count;   // Tick count
    wire [WIDTH-1:0] mask;    // Low bits that must all be one

    assign mask = ~({WIDTH{1'b1}} << shift_i);

    // Counter and pulse; a zero shift passes every tick through
    always @(posedge clk_i) begin
        if (rst_i) begin
            count   <= {WIDTH{1'b0}};
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                count   <= count + 1'b1;
                pulse_o <= ((count & mask) == mask);
            end
        end
    end
endmodule

// ### osc_ctrl_sva.sv
// Checker for osc_ctrl: bus answer, read-back and switch commit.
// Assumes a master that holds its request until ack.
module osc_ctrl_checker (
    input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire        switching_config_bit_i, new_clock_tick_i,
    input wire        switch_busy_o, secondary_osc_run_o,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i, wb_dat_o,
    input wire [2:0]  active_source_o, target_source_o,
    input wire [5:0]  fast_rc_trim_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helpers
    logic [1:0]  up;     // High from edge two after reset
    logic [4:0]  ticks;  // Raw new-clock edges seen while a switch pends
    logic        tick_d; // Previous raw tick level
    logic [31:0] rsv;    // Read-as-zero bits
    // Unmapped reads are all reserved
    always_comb begin
        case (wb_adr_i)
            8'h00:   rsv = 32'hffff_8854;
            8'h04:   rsv = 32'hffff_00ff;
            8'h08:   rsv = 32'hffff_ffc0;
            default: rsv = 32'hffff_ffff;
        endcase
    end
    // Raw edges lead the synchronised ones, so this count is an upper bound
    always_ff @(posedge clk_i) begin
        tick_d <= new_clock_tick_i;
        if (rst_i) begin
            up    <= 2'h0;
            ticks <= 5'h00;
        end else begin
            up <= {up[0], 1'b1};
            if (!switch_busy_o)
                ticks <= 5'h00;
            else if (new_clock_tick_i && !tick_d && ticks != 5'h1f)
                ticks <= ticks + 5'h01;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Key bytes excluded
    sequence sel_write;
        take ##0 (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
                  && wb_dat_i[7:0] != 8'h46 && wb_dat_i[7:0] != 8'h57);
    endsequence
    sequence tune_write;
        take ##0 (wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[0]);
    endsequence
    sequence read_back;
        wb_ack_o && !wb_we_i;
    endsequence
    a_ack_one_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one pulse");
    a_reserved_read_zero: assert property (read_back |-> (wb_dat_o & rsv) == 32'h0000_0000)
        else $error("reserved read bits not zero");
    a_current_read_back: assert property (read_back ##0 wb_adr_i == 8'h00
        |-> wb_dat_o[14:12] == $past(active_source_o))
        else $error("current source read wrong");
    a_lock_non_pll: assert property (read_back ##0 (wb_adr_i == 8'h00
        && $past(active_source_o) != 3'h1 && $past(active_source_o) != 3'h3)
        |-> !wb_dat_o[5])
        else $error("lock set without PLL");
    a_sec_osc_follows: assert property (sel_write
        |-> ##2 secondary_osc_run_o == $past(wb_dat_i[1], 2))
        else $error("secondary run wrong");
    a_trim_follows: assert property (tune_write
        |-> ##2 fast_rc_trim_o == $past(wb_dat_i[5:0], 2))
        else $error("trim output wrong");
    a_idle_source_holds: assert property (up[1] && !switch_busy_o
        |=> $stable(active_source_o))
        else $error("source changed while idle");
    a_commit_after_ticks: assert property (up[1] && $changed(active_source_o)
        |-> active_source_o == target_source_o && ticks >= 5'h0a)
        else $error("switch commit wrong");
    a_no_switch_disabled: assert property (switching_config_bit_i |-> !switch_busy_o)
        else $error("switch while disabled");
endmodule
bind osc_ctrl osc_ctrl_checker osc_ctrl_checker_inst (.*);

// ### testbench.sv
// Bench for osc_ctrl: Wishbone tasks and directed sequences.
// Assumes straps change only under reset.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [2:0]  initial_source_config_i = 3'h7;
    logic        switching_config_bit_i = 1'b0, monitor_config_bit_i = 1'b1;
    logic        pll_locked_i = 1'b0, source_ready_i = 1'b0, new_clock_tick_i = 1'b0;
    logic        failsafe_monitor_fail_i = 1'b0, interrupt_i = 1'b0, postscale_tick_i = 1'b0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, switch_busy_o, secondary_osc_run_o, postscale_pulse_o, cpu_tick_o;
    wire  [2:0]  active_source_o, target_source_o;
    wire  [5:0]  fast_rc_trim_o;
    int          fails = 0, num_checks = 0;
    logic [15:0] rdv;      // Data returned by the last bus access
    // 125 MHz clock; raw postscale enable toggles
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) postscale_tick_i <= ~postscale_tick_i;
    osc_ctrl osc_ctrl_inst (.*);
    // ==========================================================
    // Tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle, waiting for ack
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] s,
                       input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdv = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Read, compare masked bits
    task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        acc(1'b0, a, 4'h3, 16'h0000);
        check(nm, {16'h0000, rdv & m}, {16'h0000, e & m});
    endtask
    task automatic reset_dut(input logic [2:0] c, input logic sw, input logic mon);
        @(posedge clk_i);
        rst_i <= 1'b1;
        initial_source_config_i <= c;
        switching_config_bit_i  <= sw;
        monitor_config_bit_i    <= mon;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // Unlock pairs, source, request
    task automatic switch_to(input logic [2:0] src);
        acc(1'b1, 8'h00, 4'h2, 16'h7800);
        acc(1'b1, 8'h00, 4'h2, 16'h9a00);
        acc(1'b1, 8'h00, 4'h2, {5'h00, src, 8'h00});
        acc(1'b1, 8'h00, 4'h1, 16'h0046);
        acc(1'b1, 8'h00, 4'h1, 16'h0057);
        acc(1'b1, 8'h00, 4'h1, 16'h0001);
    endtask
    // New-source square wave, 8-cycle period
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_i);
            new_clock_tick_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            new_clock_tick_i <= 1'b0;
        end
    endtask
    task automatic irq;
        @(posedge clk_i);
        interrupt_i <= 1'b1;
        @(posedge clk_i);
        interrupt_i <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        reset_dut(3'h7, 1'b0, 1'b1);
        rc("select", 8'h00, 16'h7700, 16'hffff);
        rc("divider", 8'h04, 16'h3100, 16'hffff);
        rc("tune", 8'h08, 16'h0000, 16'hffff);
        rc("unmapped", 8'h0c, 16'h0000, 16'hffff);
        // Reserved bits stay clear
        acc(1'b1, 8'h04, 4'hf, 16'hffff);
        rc("divider ones", 8'h04, 16'hff00, 16'hffff);
        acc(1'b1, 8'h08, 4'hf, 16'hffff);
        rc("tune ones", 8'h08, 16'h003f, 16'hffff);
        acc(1'b1, 8'h08, 4'h3, 16'h0020);
        check("trim out", 32'(fast_rc_trim_o), 32'h0000_0020);
        // Interrupt with and without wake restore
        irq;
        rc("wake clears", 8'h04, 16'h0000, 16'h0800);
        acc(1'b1, 8'h04, 4'h2, 16'h7800);
        irq;
        rc("no wake", 8'h04, 16'h7800, 16'hff00);
        // Secondary oscillator gate
        acc(1'b1, 8'h00, 4'h1, 16'h0002);
        repeat (2) @(posedge clk_i);
        check("sec run", 32'(secondary_osc_run_o), 32'h0000_0001);
        acc(1'b1, 8'h00, 4'h1, 16'h0000);
        repeat (2) @(posedge clk_i);
        check("sec stop", 32'(secondary_osc_run_o), 32'h0000_0000);
        // Switch to primary
        source_ready_i <= 1'b1;
        switch_to(3'h2);
        rc("pending", 8'h00, 16'h7201, 16'h7701);
        ticks(8);
        check("not yet", 32'(active_source_o), 32'h0000_0007);
        ticks(6);
        check("switched", 32'(active_source_o), 32'h0000_0002);
        rc("done", 8'h00, 16'h2200, 16'h7721);
        // Freeze inert without fail-safe; switch to PLL
        acc(1'b1, 8'h00, 4'h1, 16'h0080);
        pll_locked_i <= 1'b1;
        switch_to(3'h1);
        ticks(14);
        rc("frozen ok", 8'h00, 16'h11a0, 16'h77a1);
        pll_locked_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rc("unlocked", 8'h00, 16'h0000, 16'h0020);
        switch_to(3'h1);
        rc("redundant", 8'h00, 16'h0000, 16'h0001);
        // Fail-safe on: sticky flag, freeze refuses switch
        reset_dut(3'h0, 1'b0, 1'b0);
        failsafe_monitor_fail_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        failsafe_monitor_fail_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rc("fail flag", 8'h00, 16'h0008, 16'h0008);
        acc(1'b1, 8'h00, 4'h1, 16'h0000);
        rc("fail clear", 8'h00, 16'h0000, 16'h0008);
        acc(1'b1, 8'h00, 4'h1, 16'h0080);
        acc(1'b1, 8'h00, 4'h1, 16'h0000);
        switch_to(3'h2);
        rc("frozen", 8'h00, 16'h0080, 16'h7081);
        // Switching disabled by strap
        reset_dut(3'h5, 1'b1, 1'b1);
        switch_to(3'h2);
        rc("no switching", 8'h00, 16'h5000, 16'h7001);
        end_of_test;
    end
    // Watchdog far past the run's length
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_of_test;
    end
endmodule
